// File: rtl/dtf_pkg.sv
package dtf_pkg;
   // ==================================================
   // Register offsets on the 4-bit port address
   localparam logic [3:0] OFS_ERROR_FLAGS = 4'h1;
   localparam logic [3:0] OFS_PRECOMP_START_CYLINDER = 4'h1;
   localparam logic [3:0] OFS_SECTOR_TOTAL = 4'h2;
   localparam logic [3:0] OFS_TARGET_SECTOR = 4'h3;
   localparam logic [3:0] OFS_TRACK_INDEX_LOW = 4'h4;
   localparam logic [3:0] OFS_TRACK_INDEX_HIGH = 4'h5;
   localparam logic [3:0] OFS_FORMAT_DRIVE_HEAD_SELECT = 4'h6;
   localparam logic [3:0] OFS_CONTROLLER_CONDITION = 4'h7;
   localparam logic [3:0] OFS_COMMAND = 4'h7;

   // ==================================================
   // Reset values
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [7:0] RST_SDH = 8'h20;

   // ==================================================
   // Error flag bit positions
   localparam int ERR_NO_DATA_MARK = 0;
   localparam int ERR_TRACK_ZERO = 1;
   localparam int ERR_ABORTED = 2;
   localparam int ERR_ID_NOT_FOUND = 4;
   localparam int ERR_UNCORRECTABLE = 6;
   localparam int ERR_BAD_BLOCK = 7;

   // ==================================================
   // Size/drive/head, cylinder and command field positions
   localparam int SDH_ECC = 7;
   localparam int SDH_SIZE_HI = 6;
   localparam int SDH_SIZE_LO = 5;
   localparam int SDH_DRV_HI = 4;
   localparam int SDH_DRV_LO = 3;
   localparam logic [1:0] SDH_FLOPPY = 2'h3;
   localparam int CYL_TPI_BIT = 8;
   localparam int CMD_MULTI_BIT = 2;

   // ==================================================
   // Counts and times
   localparam logic [4:0] MARK_WINDOW_BYTES = 5'h10;
   localparam logic [10:0] RESTORE_MAX_STEPS = 11'h400;
   localparam logic [4:0] ECC_MAX_BURST = 5'h05;
   localparam int PRECOMP_SHIFT_NS = 12;
   localparam int MCLK_PERIOD_NS = 100;
   // Shift is far below one clock; rounded up to one cycle, used nowhere else
   localparam int PRECOMP_SHIFT_CYC = (PRECOMP_SHIFT_NS < MCLK_PERIOD_NS) ? 1 :
                                      PRECOMP_SHIFT_NS / MCLK_PERIOD_NS;

   // ==================================================
   // Types
   typedef enum logic [3:0] {
      S_DIAG, S_IDLE, S_CHECK, S_RESTORE, S_SEEK, S_FIND, S_MARK, S_DATA, S_END
   } dtf_state_t;

   typedef enum logic [2:0] {
      C_NONE, C_RESTORE, C_SEEK, C_TEST, C_READ, C_WRITE, C_FORMAT
   } dtf_cmd_t;

   typedef struct packed {
      logic ready;
      logic wfault;
      logic wprot;
      logic seek_done_lvl;
      logic track0;
      logic step_ready;
      logic seek_end;
      logic id_found;
      logic id_bad_block;
      logic id_retry_out;
      logic disk_byte;
      logic mark_seen;
      logic sector_end;
      logic [15:0] crc_calc;
      logic [15:0] crc_stored;
      logic burst_found;
      logic [4:0] burst_len;
      logic diag_done;
      logic [2:0] diag_code;
   } dtf_drive_in_t;

   typedef struct packed {
      logic step;
      logic seek_start;
      logic ecc_fix;
      logic drq;
      logic floppy;
      logic [1:0] drive;
      logic [2:0] head;
      logic [9:0] cyl;
      logic ecc_mode;
      logic [10:0] sector_bytes;
      logic tpi_double;
      logic precomp_en;
      logic low_write_drive_level;
   } dtf_drive_out_t;

   typedef struct packed {
      dtf_state_t st;
      dtf_cmd_t kind;
      logic [7:0] cmd;
      logic [7:0] err;
      logic [7:0] precomp;
      logic [7:0] scnt;
      logic [7:0] snum;
      logic [7:0] cyl_lo;
      logic [7:0] cyl_hi;
      logic [7:0] sdh;
      logic err_bit;
      logic ecc_fixed;
      logic irq;
      logic [10:0] steps;
      logic [4:0] bytes;
      logic [7:0] rdata;
      dtf_drive_out_t drv;
   } dtf_regs_t;
endpackage

// File: rtl/dtf_regs.sv
// Functional notes
// RL1: Diagnostic result code 0..5 into error flags
// RL2: Host trusts error flags only when error bit
// RL3: Active-high command error flags at fixed bits
// RL4: No data mark within 16 bytes flags error
// RL5: Restore steps; no track zero by 1024
// RL6: Not ready or write fault aborts command
// RL7: Seek complete needed except seek; floppy forced
// RL8: Header missing after retries flags ID error
// RL9: CRC mismatch flags uncorrectable data
// RL10: ECC fixes bursts up to five bits
// RL11: Bad block marker flags bad block error
// RL12: Precomp register times four starts precomp
// RL13: Fixed twelve ns shift, floppy unaffected
// RL14: Sector count sizes transfer, decrements per sector
// RL15: Sector number targets and reports failing sector
// RL16: Ten-bit cylinder from low and high registers
// RL17: Floppy with cylinder bit 8 double-steps
// RL18: Size/drive/head bit 7 selects ECC
// RL19: Bits 6:5 decode sector size
// RL20: Bits 4:3 select hard drive or floppy
// RL21: Host ignores status while busy
// RL22: Status read clears pending interrupt
// RL23: Error bit set on failure, cleared on issue
`timescale 1ns/1ps
module dtf_regs (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Host port
   input wire logic [3:0] io_addr,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic irq,
   // Drive side
   input wire dtf_pkg::dtf_drive_in_t drv_in,
   output dtf_pkg::dtf_drive_out_t drv_out
);
   import dtf_pkg::*;

   dtf_regs_t r_ff;
   dtf_regs_t nxt_r;

   // ==================================================
   // Decoders
   function automatic dtf_cmd_t cmd_kind(input logic [7:0] c);
      unique casez (c)
         8'b0001_????: cmd_kind = C_RESTORE;
         8'b0111_????: cmd_kind = C_SEEK;
         8'h90: cmd_kind = C_TEST;
         8'b0010_???0: cmd_kind = C_READ;
         8'b0011_0??0: cmd_kind = C_WRITE;
         8'h50: cmd_kind = C_FORMAT;
         default: cmd_kind = C_NONE;
      endcase
   endfunction

   function automatic logic is_floppy(input logic [7:0] sdh);
      is_floppy = (sdh[SDH_DRV_HI:SDH_DRV_LO] == SDH_FLOPPY);
   endfunction

   function automatic logic [10:0] size_bytes(input logic [1:0] code);
      unique case (code)
         2'h0: size_bytes = 11'h100;
         2'h1: size_bytes = 11'h200;
         2'h2: size_bytes = 11'h400;
         2'h3: size_bytes = 11'h080;
      endcase
   endfunction

   // ==================================================
   // Effective drive status
   logic busy;
   logic flp;
   logic rdy_eff;
   logic wf_eff;
   logic sc_eff;
   logic [7:0] status;
   logic [9:0] cyl10;
   dtf_cmd_t kind_now;

   always_comb
   begin
      busy = (r_ff.st != S_IDLE);
      flp = is_floppy(r_ff.sdh);
      rdy_eff = flp | drv_in.ready;
      // Write-protected floppy counts as write fault
      wf_eff = flp ? drv_in.wprot : drv_in.wfault; // [RL6]
      sc_eff = flp | drv_in.seek_done_lvl; // [RL7]
      status = {busy, rdy_eff, wf_eff, sc_eff, r_ff.drv.drq, r_ff.ecc_fixed, 1'b0,
                r_ff.err_bit};
      cyl10 = {r_ff.cyl_hi[1:0], r_ff.cyl_lo}; // [RL16]
      kind_now = cmd_kind(io_wdata);
   end

   // ==================================================
   // Next state
   always_comb
   begin
      nxt_r = r_ff;
      nxt_r.drv.step = 1'b0;
      nxt_r.drv.seek_start = 1'b0;
      nxt_r.drv.ecc_fix = 1'b0;
      nxt_r.rdata = 8'h00;

      // Host reads
      if (io_rd)
      begin
         unique case (io_addr)
            OFS_ERROR_FLAGS: nxt_r.rdata = r_ff.err;
            OFS_SECTOR_TOTAL: nxt_r.rdata = r_ff.scnt;
            OFS_TARGET_SECTOR: nxt_r.rdata = r_ff.snum; // [RL15]
            OFS_TRACK_INDEX_LOW: nxt_r.rdata = r_ff.cyl_lo;
            OFS_TRACK_INDEX_HIGH: nxt_r.rdata = r_ff.cyl_hi;
            OFS_FORMAT_DRIVE_HEAD_SELECT: nxt_r.rdata = r_ff.sdh;
            OFS_CONTROLLER_CONDITION: nxt_r.rdata = status;
            default: nxt_r.rdata = 8'h00;
         endcase
         if (io_addr == OFS_CONTROLLER_CONDITION)
            nxt_r.irq = 1'b0; // [RL22]
      end

      // Host writes are taken only while idle
      if (io_wr && !busy)
      begin
         unique case (io_addr)
            OFS_PRECOMP_START_CYLINDER: nxt_r.precomp = io_wdata;
            OFS_SECTOR_TOTAL: nxt_r.scnt = io_wdata;
            OFS_TARGET_SECTOR: nxt_r.snum = io_wdata;
            OFS_TRACK_INDEX_LOW: nxt_r.cyl_lo = io_wdata;
            OFS_TRACK_INDEX_HIGH: nxt_r.cyl_hi = io_wdata;
            OFS_FORMAT_DRIVE_HEAD_SELECT: nxt_r.sdh = io_wdata;
            OFS_COMMAND:
            begin
               nxt_r.cmd = io_wdata;
               nxt_r.kind = kind_now;
               nxt_r.err = RST_REG;
               nxt_r.err_bit = 1'b0; // [RL23]
               nxt_r.ecc_fixed = 1'b0;
               nxt_r.irq = 1'b0;
               nxt_r.st = S_CHECK;
            end
            default: ;
         endcase
      end

      unique case (r_ff.st)
         S_DIAG:
            if (drv_in.diag_done)
            begin
               nxt_r.err = {5'h00, drv_in.diag_code}; // [RL1]
               nxt_r.st = S_IDLE;
            end
         S_IDLE: ;
         S_CHECK:
            if (r_ff.kind == C_TEST)
               nxt_r.st = S_DIAG;
            else if (r_ff.kind == C_NONE || !rdy_eff ||
                     (wf_eff && (r_ff.kind != C_READ || !flp)) ||
                     (!sc_eff && r_ff.kind != C_SEEK))
            begin
               nxt_r.err[ERR_ABORTED] = 1'b1; // [RL6] [RL7]
               nxt_r.st = S_END;
            end
            else
            begin
               nxt_r.steps = 11'h000;
               unique case (r_ff.kind)
                  C_RESTORE: nxt_r.st = S_RESTORE;
                  C_SEEK:
                  begin
                     nxt_r.drv.seek_start = 1'b1;
                     nxt_r.st = S_SEEK;
                  end
                  C_FORMAT: nxt_r.st = S_DATA; // [RL14]
                  default: nxt_r.st = S_FIND;
               endcase
            end
         S_RESTORE:
            if (drv_in.track0)
               nxt_r.st = S_END;
            else if (r_ff.steps == RESTORE_MAX_STEPS)
            begin
               nxt_r.err[ERR_TRACK_ZERO] = 1'b1; // [RL5]
               nxt_r.st = S_END;
            end
            else if (drv_in.step_ready && !r_ff.drv.step)
            begin
               nxt_r.drv.step = 1'b1; // [RL5]
               nxt_r.steps = r_ff.steps + 11'h001;
            end
         S_SEEK:
            if (drv_in.seek_end)
               nxt_r.st = S_END;
         S_FIND:
            if (drv_in.id_found && drv_in.id_bad_block)
            begin
               nxt_r.err[ERR_BAD_BLOCK] = 1'b1; // [RL11]
               nxt_r.st = S_END;
            end
            else if (drv_in.id_found)
            begin
               nxt_r.bytes = 5'h00;
               nxt_r.st = S_MARK;
            end
            else if (drv_in.id_retry_out)
            begin
               nxt_r.err[ERR_ID_NOT_FOUND] = 1'b1; // [RL8]
               nxt_r.st = S_END;
            end
         S_MARK:
            if (drv_in.mark_seen)
               nxt_r.st = S_DATA;
            else if (drv_in.disk_byte)
            begin
               nxt_r.bytes = r_ff.bytes + 5'h01;
               if (r_ff.bytes + 5'h01 == MARK_WINDOW_BYTES)
               begin
                  nxt_r.err[ERR_NO_DATA_MARK] = 1'b1; // [RL4]
                  nxt_r.st = S_END;
               end
            end
         S_DATA:
            if (drv_in.sector_end)
            begin
               if (!r_ff.drv.ecc_mode && drv_in.crc_calc != drv_in.crc_stored)
               begin
                  nxt_r.err[ERR_UNCORRECTABLE] = 1'b1; // [RL9]
                  nxt_r.st = S_END;
               end
               else if (r_ff.drv.ecc_mode && drv_in.burst_found &&
                        drv_in.burst_len > ECC_MAX_BURST)
               begin
                  nxt_r.err[ERR_UNCORRECTABLE] = 1'b1; // [RL10]
                  nxt_r.st = S_END;
               end
               else
               begin
                  if (r_ff.drv.ecc_mode && drv_in.burst_found)
                  begin
                     nxt_r.ecc_fixed = 1'b1; // [RL10]
                     nxt_r.drv.ecc_fix = 1'b1;
                  end
                  nxt_r.scnt = r_ff.scnt - 8'h01; // [RL14]
                  if (r_ff.scnt > 8'h01 &&
                      (r_ff.kind == C_FORMAT || r_ff.cmd[CMD_MULTI_BIT]))
                  begin
                     nxt_r.snum = r_ff.snum + 8'h01; // [RL15]
                     nxt_r.st = (r_ff.kind == C_FORMAT) ? S_DATA : S_FIND;
                  end
                  else
                     nxt_r.st = S_END;
               end
            end
         S_END:
         begin
            nxt_r.err_bit = |r_ff.err; // [RL23] [RL3]
            nxt_r.irq = 1'b1;
            nxt_r.st = S_IDLE;
         end
      endcase

      // Drive-side decode of the selector and cylinder
      nxt_r.drv.drq = (nxt_r.st == S_DATA);
      nxt_r.drv.floppy = is_floppy(nxt_r.sdh); // [RL20]
      nxt_r.drv.drive = nxt_r.drv.floppy ? nxt_r.sdh[2:1] : nxt_r.sdh[SDH_DRV_HI:SDH_DRV_LO];
      nxt_r.drv.head = nxt_r.drv.floppy ? {2'h0, nxt_r.sdh[0]} : nxt_r.sdh[2:0]; // [RL20]
      nxt_r.drv.cyl = {nxt_r.cyl_hi[1:0], nxt_r.cyl_lo}; // [RL16]
      nxt_r.drv.ecc_mode = nxt_r.sdh[SDH_ECC]; // [RL18]
      nxt_r.drv.sector_bytes = size_bytes(nxt_r.sdh[SDH_SIZE_HI:SDH_SIZE_LO]); // [RL19]
      nxt_r.drv.tpi_double = nxt_r.drv.floppy & nxt_r.cyl_hi[CYL_TPI_BIT - 8]; // [RL17]
      // Floppy precomp never follows this register
      nxt_r.drv.precomp_en = !nxt_r.drv.floppy &&
                             ({nxt_r.cyl_hi[1:0], nxt_r.cyl_lo} >=
                              {nxt_r.precomp, 2'b00}); // [RL12] [RL13]
      nxt_r.drv.low_write_drive_level = nxt_r.drv.precomp_en; // [RL12]
   end

   // ==================================================
   // State register
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         r_ff <= '0;
         r_ff.st <= S_DIAG;
         r_ff.kind <= C_NONE;
         r_ff.sdh <= RST_SDH;
         r_ff.drv.sector_bytes <= 11'h200;
         r_ff.drv.precomp_en <= 1'b1;
         r_ff.drv.low_write_drive_level <= 1'b1;
      end
      else
         r_ff <= nxt_r;
   end

   assign io_rdata = r_ff.rdata;
   assign irq = r_ff.irq;
   assign drv_out = r_ff.drv;

   // ==================================================
   // Checks
   sequence s_cmd_issue;
      io_wr && !busy && io_addr == OFS_COMMAND;
   endsequence

   sequence s_header_found;
      r_ff.st == S_FIND && drv_in.id_found && !drv_in.id_bad_block;
   endsequence

   chk_diag_code: assert property (@(posedge mclk) disable iff (!rst_n) // [RL1]
      r_ff.st == S_DIAG && drv_in.diag_done |=> r_ff.err == {5'h00, $past(drv_in.diag_code)}
      && !r_ff.err_bit)
      else $error("diagnostic code not posted");

   chk_unused_bits: assert property (@(posedge mclk) disable iff (!rst_n) // [RL3]
      r_ff.st != S_DIAG && $past(r_ff.st) != S_DIAG |-> !r_ff.err[3] && !r_ff.err[5])
      else $error("unused error bit set");

   chk_mark_start: assert property (@(posedge mclk) disable iff (!rst_n) // [RL4]
      s_header_found |=> r_ff.st == S_MARK && r_ff.bytes == 5'h00)
      else $error("mark window not started at header");

   chk_mark_count: assert property (@(posedge mclk) disable iff (!rst_n) // [RL4]
      r_ff.st == S_MARK && drv_in.disk_byte && !drv_in.mark_seen
      && r_ff.bytes < MARK_WINDOW_BYTES - 5'h01
      |=> r_ff.st == S_MARK && r_ff.bytes == $past(r_ff.bytes) + 5'h01)
      else $error("mark window byte not counted");

   chk_mark_window: assert property (@(posedge mclk) disable iff (!rst_n) // [RL4]
      r_ff.st == S_MARK && drv_in.disk_byte && !drv_in.mark_seen
      && r_ff.bytes == MARK_WINDOW_BYTES - 5'h01 |=> r_ff.err[ERR_NO_DATA_MARK])
      else $error("missing mark not flagged after 16 bytes");

   chk_id_missing: assert property (@(posedge mclk) disable iff (!rst_n) // [RL8]
      r_ff.st == S_FIND && !drv_in.id_found && drv_in.id_retry_out
      |=> r_ff.err[ERR_ID_NOT_FOUND] && r_ff.st == S_END)
      else $error("missing header not flagged");

   chk_bad_block: assert property (@(posedge mclk) disable iff (!rst_n) // [RL11]
      r_ff.st == S_FIND && drv_in.id_found && drv_in.id_bad_block
      |=> r_ff.err[ERR_BAD_BLOCK] && r_ff.st == S_END)
      else $error("bad block marker not flagged");

   chk_restore_limit: assert property (@(posedge mclk) disable iff (!rst_n) // [RL5]
      r_ff.st == S_RESTORE |-> r_ff.steps <= RESTORE_MAX_STEPS)
      else $error("restore stepped past limit");

   chk_abort_ready: assert property (@(posedge mclk) disable iff (!rst_n) // [RL6]
      r_ff.st == S_CHECK && r_ff.kind != C_TEST && !rdy_eff
      |=> r_ff.err[ERR_ABORTED] && r_ff.st == S_END ##1 r_ff.err_bit)
      else $error("not ready did not abort");

   chk_floppy_settled: assert property (@(posedge mclk) disable iff (!rst_n) // [RL7]
      flp |-> status[4] && status[6])
      else $error("floppy status not forced");

   chk_crc_flag: assert property (@(posedge mclk) disable iff (!rst_n) // [RL9]
      r_ff.st == S_DATA && drv_in.sector_end && !r_ff.drv.ecc_mode
      && drv_in.crc_calc != drv_in.crc_stored |=> r_ff.err[ERR_UNCORRECTABLE])
      else $error("crc mismatch not flagged");

   chk_count_step: assert property (@(posedge mclk) disable iff (!rst_n) // [RL14]
      r_ff.st == S_DATA && drv_in.sector_end && nxt_r.st != S_END
      |=> r_ff.scnt == $past(r_ff.scnt) - 8'h01)
      else $error("sector count not decremented");

   chk_status_clear: assert property (@(posedge mclk) disable iff (!rst_n) // [RL22]
      io_rd && io_addr == OFS_CONTROLLER_CONDITION && r_ff.st != S_END |=> !irq)
      else $error("status read left interrupt pending");

   chk_issue_clears: assert property (@(posedge mclk) disable iff (!rst_n) // [RL23]
      s_cmd_issue |=> !r_ff.err_bit && r_ff.st == S_CHECK)
      else $error("command issue did not clear error bit");

   chk_precomp_cyl: assert property (@(posedge mclk) disable iff (!rst_n) // [RL12]
      !drv_out.floppy && drv_out.cyl >= {r_ff.precomp, 2'b00} |-> drv_out.precomp_en)
      else $error("precomp not enabled past start cylinder");
endmodule

// File: testbench/dtf_drive_model.sv
`timescale 1ns/1ps
module dtf_drive_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Design drive side
   input wire dtf_pkg::dtf_drive_out_t drv_out,
   output dtf_pkg::dtf_drive_in_t drv_in,
   // Scenario controls
   input wire logic ready,
   input wire logic wfault,
   input wire logic wprot,
   input wire logic settled,
   input wire logic pos_load,
   input wire integer pos_init,
   input wire logic [2:0] diag_code,
   input wire logic [1:0] id_mode,
   input wire integer mark_at,
   input wire logic crc_bad,
   input wire logic [4:0] burst,
   output int steps
);
   import dtf_pkg::*;
   // ==================================================
   // Spinning disk: one sector passes every 48 cycles
   int phase;
   int pos;
   int seek_cnt;
   logic fin;

   always @(posedge mclk)
   begin
      if (!rst_n || pos_load)
      begin
         pos <= pos_init;
         steps <= 0;
      end
      else if (drv_out.step)
      begin
         steps <= steps + 1;
         pos <= (pos > 0) ? pos - 1 : 0;
      end
      phase <= (!rst_n || phase == 47) ? 0 : phase + 1;
      if (!rst_n)
         seek_cnt <= 0;
      else if (drv_out.seek_start)
         seek_cnt <= 4;
      else if (seek_cnt > 0)
         seek_cnt <= seek_cnt - 1;
   end

   // ==================================================
   // Qualified fields show junk outside their strobe
   always_comb
   begin
      fin = (phase == 46);
      drv_in = '0;
      drv_in.ready = ready;
      drv_in.wfault = wfault;
      drv_in.wprot = wprot;
      drv_in.seek_done_lvl = settled && (seek_cnt == 0);
      drv_in.track0 = (pos == 0);
      drv_in.step_ready = 1'b1;
      drv_in.seek_end = (seek_cnt == 1);
      drv_in.id_found = (phase == 0) && (id_mode != 2'h1);
      drv_in.id_bad_block = (phase == 0) && (id_mode == 2'h2);
      drv_in.id_retry_out = (phase == 0) && (id_mode == 2'h1);
      drv_in.disk_byte = (phase > 0) && (phase < 45) && (phase % 2 == 0);
      drv_in.mark_seen = (phase == 2 * mark_at);
      drv_in.sector_end = fin;
      drv_in.crc_calc = fin ? 16'h5a3c : phase[15:0];
      drv_in.crc_stored = fin ? (crc_bad ? 16'h5a3d : 16'h5a3c) : ~phase[15:0];
      drv_in.burst_found = fin && (burst != 5'h00);
      drv_in.burst_len = fin ? burst : ~burst;
      drv_in.diag_done = (phase == 20);
      drv_in.diag_code = (phase == 20) ? diag_code : ~diag_code;
   end
endmodule

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
   import dtf_pkg::*;
   // ==================================================
   // Signals
   logic mclk, rst_n, io_rd, io_wr, irq;
   logic [3:0] io_addr;
   logic [7:0] io_wdata, io_rdata, st, d;
   dtf_drive_in_t drv_in;
   dtf_drive_out_t drv_out;
   logic ready = 1, wfault = 0, wprot = 0, settled = 1, pos_load = 0, crc_bad = 0;
   int pos_init = 3, mark_at = 3, steps, pc = 0, fixes = 0;
   logic [2:0] diag_code = 3'h3;
   logic [1:0] id_mode = 2'h0;
   logic [4:0] burst = 5'h00;
   logic irq_seen = 0;
   int n_errors = 0, total_checks = 0;
   int ref_reg [8] = '{0, 0, 0, 0, 0, 0, 8'h20, 0};
   int sizes [4] = '{256, 512, 1024, 128};

   dtf_regs u_dtf_regs (.mclk(mclk), .rst_n(rst_n), .io_addr(io_addr), .io_rd(io_rd),
      .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata), .irq(irq),
      .drv_in(drv_in), .drv_out(drv_out));
   dtf_drive_model u_dtf_drive_model (.mclk(mclk), .rst_n(rst_n), .drv_out(drv_out),
      .drv_in(drv_in), .ready(ready), .wfault(wfault), .wprot(wprot), .settled(settled),
      .pos_load(pos_load), .pos_init(pos_init), .diag_code(diag_code), .id_mode(id_mode),
      .mark_at(mark_at), .crc_bad(crc_bad), .burst(burst), .steps(steps));

   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   always @(posedge mclk)
   begin
      if (irq === 1'b1)
         irq_seen <= 1'b1;
      if (drv_out.ecc_fix === 1'b1)
         fixes <= fixes + 1;
   end

   // ==================================================
   // Host tasks
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge mclk);
      #10;
      io_addr = a;
      io_wdata = v;
      io_wr = 1'b1;
      @(posedge mclk);
      #10;
      io_wr = 1'b0;
   endtask

   task automatic setr(input logic [3:0] a, input logic [7:0] v);
      wr(a, v);
      if (a == 4'h1)
         pc = v;
      else
         ref_reg[a] = v;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge mclk);
      #10;
      io_addr = a;
      io_rd = 1'b1;
      @(posedge mclk);
      #10;
      io_rd = 1'b0;
      v = io_rdata;
   endtask

   task automatic wait_idle;
      int k;
      k = 0;
      st = 8'hff;
      while (st[7] !== 1'b0 && k < 4000)
      begin
         rd(4'h7, st);
         k++;
      end
      chk("busy", st[7], 1'b0);
   endtask

   task automatic run(input string nm, input logic [7:0] cmd, input logic [7:0] exp);
      irq_seen = 1'b0;
      fixes = 0;
      wr(4'h7, cmd);
      wait_idle;
      repeat (4) @(posedge mclk);
      rd(4'h7, st);
      @(posedge mclk);
      #10;
      chk({nm, " irq"}, irq, 1'b0);
      if (cmd != 8'h90)
         chk({nm, " irq raised"}, irq_seen, 1'b1);
      chk({nm, " error bit"}, st[0], exp != 0 && cmd != 8'h90);
      rd(4'h1, d);
      chk({nm, " flags"}, d, exp);
   endtask

   task automatic cs(input string nm, input logic [7:0] cmd, input logic [7:0] sdh,
      input logic [3:0] kn, input logic [1:0] idm, input int mk, input logic crc,
      input logic [4:0] bu, input logic [7:0] exp);
      @(posedge mclk);
      #10;
      {ready, wfault, wprot, settled} = kn;
      id_mode = idm;
      mark_at = mk;
      crc_bad = crc;
      burst = bu;
      setr(4'h6, sdh);
      run(nm, cmd, exp);
   endtask

   task automatic chk_decode;
      int s, cyl, hard;
      repeat (2) @(posedge mclk);
      #10;
      s = ref_reg[6];
      cyl = (ref_reg[5] % 4) * 256 + ref_reg[4];
      hard = ((s >> 3) % 4) != 3;
      chk("cylinder", drv_out.cyl, cyl);
      chk("size", drv_out.sector_bytes, sizes[(s >> 5) % 4]);
      chk("floppy", drv_out.floppy, !hard);
      chk("drive", drv_out.drive, hard ? (s >> 3) % 4 : (s >> 1) % 4);
      chk("head", drv_out.head, hard ? s % 8 : s % 2);
      chk("tpi", drv_out.tpi_double, !hard && (ref_reg[5] % 2));
      if (hard)
         chk("ecc", drv_out.ecc_mode, s >> 7);
      chk("precomp", drv_out.precomp_en, hard && cyl >= pc * 4);
      chk("low drive", drv_out.low_write_drive_level, hard && cyl >= pc * 4);
   endtask

   task automatic restore(input int p, input logic [7:0] exp);
      @(posedge mclk);
      #10;
      pos_init = p;
      pos_load = 1'b1;
      @(posedge mclk);
      #10;
      pos_load = 1'b0;
      run("restore", 8'h10, exp);
      chk("steps", steps, (p > 1024) ? 1024 : p);
   endtask

   task automatic conclude;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      #(100 * 80000);
      n_errors++;
      conclude;
   end

   // ==================================================
   // Main sequence
   initial
   begin
      {io_addr, io_rd, io_wr, io_wdata} = '0;
      rst_n = 1'b0;
      void'($urandom(70564));
      repeat (20) @(posedge mclk);
      #10;
      rst_n = 1'b1;
      wr(4'h2, 8'h55);
      rd(4'h2, d);
      chk("write while busy", d, 8'h00);
      wait_idle;
      chk("diag error bit", st[0], 1'b0);
      rd(4'h1, d);
      chk("diag code", d, 8'h03);
      for (int a = 0; a < 16; a++)
      begin
         if (a != 1 && a != 7)
         begin
            rd(a[3:0], d);
            chk("reset value", d, (a > 1 && a < 7) ? ref_reg[a] : 0);
         end
      end
      @(posedge mclk);
      #10;
      chk("rdata release", io_rdata, 8'h00);
      repeat (6)
      begin
         for (int a = 1; a < 7; a++)
            setr(a[3:0], $urandom % 256);
         for (int a = 2; a < 7; a++)
         begin
            rd(a[3:0], d);
            chk("read back", d, ref_reg[a]);
         end
         chk_decode;
      end
      setr(4'h6, 8'h20);
      setr(4'h1, 8'h80);
      setr(4'h5, 8'h01);
      setr(4'h4, 8'hff);
      chk_decode;
      setr(4'h5, 8'h02);
      setr(4'h4, 8'h00);
      chk_decode;
      setr(4'h4, 8'h03);
      chk_decode;
      for (int c = 0; c < 6; c++)
      begin
         diag_code = c[2:0];
         run("test", 8'h90, c[7:0]);
      end
      restore(1023, 8'h00);
      restore(3000, 8'h02);
      cs("read", 8'h20, 8'h20, 4'b1001, 2'h0, 3, 1'b0, 5'h00, 8'h00);
      cs("not ready", 8'h20, 8'h20, 4'b0001, 2'h0, 3, 1'b0, 5'h00, 8'h04);
      cs("fault", 8'h30, 8'h20, 4'b1101, 2'h0, 3, 1'b0, 5'h00, 8'h04);
      cs("unsettled", 8'h20, 8'h20, 4'b1000, 2'h0, 3, 1'b0, 5'h00, 8'h04);
      cs("seek", 8'h70, 8'h20, 4'b1000, 2'h0, 3, 1'b0, 5'h00, 8'h00);
      cs("no id", 8'h20, 8'h20, 4'b1001, 2'h1, 3, 1'b0, 5'h00, 8'h10);
      cs("bad block", 8'h30, 8'h20, 4'b1001, 2'h2, 3, 1'b0, 5'h00, 8'h80);
      cs("mark 16", 8'h20, 8'h20, 4'b1001, 2'h0, 16, 1'b0, 5'h00, 8'h00);
      cs("mark 17", 8'h20, 8'h20, 4'b1001, 2'h0, 17, 1'b0, 5'h00, 8'h01);
      cs("crc", 8'h20, 8'h20, 4'b1001, 2'h0, 3, 1'b1, 5'h00, 8'h40);
      cs("burst 5", 8'h20, 8'ha0, 4'b1001, 2'h0, 3, 1'b0, 5'h05, 8'h00);
      chk("ecc fixed", st[2], 1'b1);
      chk("ecc pulses", fixes, 1);
      cs("burst 6", 8'h20, 8'ha0, 4'b1001, 2'h0, 3, 1'b0, 5'h06, 8'h40);
      cs("floppy read", 8'h20, 8'h38, 4'b1010, 2'h0, 3, 1'b0, 5'h00, 8'h00);
      chk("floppy settled", st[4], 1'b1);
      cs("floppy write", 8'h30, 8'h38, 4'b1011, 2'h0, 3, 1'b0, 5'h00, 8'h04);
      setr(4'h2, 8'h03);
      setr(4'h3, 8'h05);
      cs("multi", 8'h24, 8'h20, 4'b1001, 2'h0, 3, 1'b0, 5'h00, 8'h00);
      rd(4'h2, d);
      chk("count left", d, 8'h00);
      rd(4'h3, d);
      chk("last sector", d, 8'h07);
      setr(4'h3, 8'h09);
      cs("multi crc", 8'h24, 8'h20, 4'b1001, 2'h0, 3, 1'b1, 5'h00, 8'h40);
      rd(4'h3, d);
      chk("failing sector", d, 8'h09);
      setr(4'h2, 8'h02);
      cs("format", 8'h50, 8'h20, 4'b1001, 2'h0, 3, 1'b0, 5'h00, 8'h00);
      rd(4'h2, d);
      chk("format count", d, 8'h00);
      conclude;
   end
endmodule
